//--- design/sse_spi_status.sv
`timescale 1ns/1ps
// What this block does
// - Count field shows pending or unread transfers
// - Select 111: interrupt while transmit full
// - Select 110: interrupt when transmit FIFO empties
// - Select 101: interrupt when transmission completes
// - Select 100: interrupt when one location frees
// - Transmit full set on filling, cleared on freeing
// - Receive full set on filling, cleared on freeing
module sse_spi_status
  import sse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sse_eng_t eng,
  output logic [DATA_W-1:0] tx_word,
  output logic tx_word_valid,
  output logic irq
);
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [1:0] ists_r, ists_nxt, imsk_r, imsk_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic ovf_r, ovf_nxt, shempty_r, shempty_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [DATA_W-1:0] txw_r, txw_nxt;
  logic txv_r, txv_nxt;
  logic enh, master, wr_done, rd_done, hit, sel_ev;
  logic tx_push, tx_pop, rx_push, rx_pop, ovf_set;
  logic tx_full, rx_full;
  logic [CNT_W-1:0] tx_cnt, rx_cnt, tx_after, limit;
  logic [DATA_W-1:0] tx_head, rx_head;

  function automatic logic mapped(input logic [11:0] a);
    return a == ADDR_STAT || a == ADDR_DATA || a == ADDR_CTRL ||
           a == ADDR_ISTS || a == ADDR_IMSK;
  endfunction

  function automatic logic is_full(input logic [CNT_W-1:0] c,
                                   input logic [CNT_W-1:0] lim);
    return c >= lim;
  endfunction

  assign enh = ctrl_r[CTRL_ENH];
  assign master = ctrl_r[CTRL_MST];
  // Standard mode behaves as a one-deep buffer
  assign limit = enh ? LIMIT_ENH : LIMIT_STD;
  assign tx_full = is_full(tx_cnt, limit);
  assign rx_full = is_full(rx_cnt, limit);
  assign wr_done = psel && penable && pready_r && pwrite;
  assign rd_done = psel && penable && pready_r && !pwrite;
  // Writes to a full transmit buffer are dropped
  assign tx_push = wr_done && paddr == ADDR_DATA && !tx_full;
  assign tx_pop = eng.load && tx_cnt != 4'h0;
  assign rx_pop = rd_done && paddr == ADDR_DATA && rx_cnt != 4'h0;
  assign rx_push = eng.push && !rx_full;
  assign ovf_set = eng.push && rx_full;
  assign tx_after = tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};

  sse_fifo u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .push(tx_push),
    .pop(tx_pop),
    .wdata(pwdata[DATA_W-1:0]),
    .head(tx_head),
    .count(tx_cnt)
  );

  sse_fifo u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .push(rx_push),
    .pop(rx_pop),
    .wdata(eng.data),
    .head(rx_head),
    .count(rx_cnt)
  );

  always_comb
  begin
    case (sel_r)
      SEL_TX_FULL: sel_ev = tx_full;
      SEL_TX_EMPTY: sel_ev = tx_pop && tx_after == 4'h0;
      SEL_TX_DONE: sel_ev = eng.done;
      SEL_TX_ONE_FREE: sel_ev = tx_pop && tx_after == limit - 4'h1;
      SEL_RX_FULL: sel_ev = rx_full;
      SEL_RX_3Q: sel_ev = rx_cnt >= RX_3Q_LEVEL;
      SEL_RX_ANY: sel_ev = rx_cnt != 4'h0;
      SEL_RX_LAST_READ: sel_ev = rx_pop && rx_cnt == 4'h1;
      default: sel_ev = 1'b0;
    endcase
  end

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    imsk_nxt = imsk_r;
    sel_nxt = sel_r;
    ists_nxt = ists_r;
    ovf_nxt = ovf_r;
    shempty_nxt = shempty_r;
    txw_nxt = txw_r;
    txv_nxt = tx_pop;
    if (wr_done)
    begin
      case (paddr)
        ADDR_CTRL: ctrl_nxt = pwdata[1:0];
        ADDR_IMSK: imsk_nxt = pwdata[1:0];
        ADDR_ISTS: ists_nxt = ists_r & ~pwdata[1:0];
        ADDR_STAT:
        begin
          sel_nxt = pwdata[ST_SEL_LSB +: 3];
          if (!pwdata[ST_RX_OVF])
            ovf_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    // Sets after clears so a same-cycle event is kept
    if (ovf_set)
    begin
      ovf_nxt = 1'b1;
      ists_nxt[IRQ_OVF_EV] = 1'b1;
    end
    if (sel_ev)
      ists_nxt[IRQ_SEL_EV] = 1'b1;
    // New load outranks completion of the previous word
    if (tx_pop)
    begin
      shempty_nxt = 1'b0;
      txw_nxt = tx_head;
    end
    else if (eng.done)
      shempty_nxt = 1'b1;
    irq_nxt = |(ists_r & imsk_r);
  end

  // Bus: one wait state, then pready for one cycle
  always_comb
  begin
    pready_nxt = psel && penable && !pready_r;
    pslverr_nxt = pready_nxt && !mapped(paddr);
    prdata_nxt = prdata_r;
    if (pready_nxt && !pwrite)
    begin
      case (paddr)
        ADDR_STAT:
        begin
          prdata_nxt = 32'h0000_0000;
          prdata_nxt[ST_BEC_LSB +: 3] = master ? tx_cnt[2:0]
                                               : rx_cnt[2:0];
          prdata_nxt[ST_SHIFT_EMPTY] = shempty_r;
          prdata_nxt[ST_RX_OVF] = ovf_r;
          prdata_nxt[ST_RX_EMPTY] = rx_cnt == 4'h0;
          prdata_nxt[ST_SEL_LSB +: 3] = sel_r;
          prdata_nxt[ST_TX_FULL] = tx_full;
          prdata_nxt[ST_RX_FULL] = rx_full;
        end
        ADDR_DATA: prdata_nxt = {16'h0000, rx_head};
        ADDR_CTRL: prdata_nxt = {30'h0000_0000, ctrl_r};
        ADDR_ISTS: prdata_nxt = {30'h0000_0000, ists_r};
        ADDR_IMSK: prdata_nxt = {30'h0000_0000, imsk_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= CTRL_RST;
      imsk_r <= IRQ_RST;
      ists_r <= IRQ_RST;
      sel_r <= SEL_RST;
      ovf_r <= 1'b0;
      shempty_r <= 1'b1;
      txw_r <= 16'h0000;
      txv_r <= 1'b0;
      irq_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
      imsk_r <= imsk_nxt;
      ists_r <= ists_nxt;
      sel_r <= sel_nxt;
      ovf_r <= ovf_nxt;
      shempty_r <= shempty_nxt;
      txw_r <= txw_nxt;
      txv_r <= txv_nxt;
      irq_r <= irq_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_word = txw_r;
  assign tx_word_valid = txv_r;
  assign irq = irq_r;

  property p_ovf_set;
    @(posedge pclk) disable iff (!presetn)
    ce && eng.push && rx_full |=> ovf_r ##1 (ovf_r || $past(wr_done));
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set");

  property p_ovf_discard;
    @(posedge pclk) disable iff (!presetn)
    ce && eng.push && rx_full && !rx_pop |=> $stable(rx_cnt);
  endproperty
  a_ovf_discard: assert property (p_ovf_discard)
    else $error("overflowing word was stored");

  property p_tx_fill;
    @(posedge pclk) disable iff (!presetn)
    ce && tx_push && !tx_pop && tx_cnt == limit - 4'h1 |=> tx_full;
  endproperty
  a_tx_fill: assert property (p_tx_fill)
    else $error("transmit full not set");

  property p_rx_fill;
    @(posedge pclk) disable iff (!presetn)
    ce && rx_push && !rx_pop && rx_cnt == limit - 4'h1 && !wr_done
      |=> rx_full;
  endproperty
  a_rx_fill: assert property (p_rx_fill)
    else $error("receive full not set");

  property p_sel_full;
    @(posedge pclk) disable iff (!presetn)
    ce && sel_r == SEL_TX_FULL && tx_full |=> ists_r[IRQ_SEL_EV];
  endproperty
  a_sel_full: assert property (p_sel_full)
    else $error("transmit full event missed");

  property p_sel_empty;
    @(posedge pclk) disable iff (!presetn)
    ce && sel_r == SEL_TX_EMPTY && tx_pop && tx_cnt == 4'h1 && !tx_push
      |=> ists_r[IRQ_SEL_EV] && !shempty_r;
  endproperty
  a_sel_empty: assert property (p_sel_empty)
    else $error("transmit empty event missed");

  property p_sel_done;
    @(posedge pclk) disable iff (!presetn)
    ce && sel_r == SEL_TX_DONE && eng.done && !tx_pop
      |=> ists_r[IRQ_SEL_EV] && shempty_r;
  endproperty
  a_sel_done: assert property (p_sel_done)
    else $error("transmit done event missed");

  property p_sel_one;
    @(posedge pclk) disable iff (!presetn)
    ce && sel_r == SEL_TX_ONE_FREE && tx_pop && tx_cnt == limit && !tx_push
      |=> ists_r[IRQ_SEL_EV] ##1 (irq || !$past(imsk_r[IRQ_SEL_EV])
      || !$past(ce));
  endproperty
  a_sel_one: assert property (p_sel_one)
    else $error("one free location event missed");
endmodule

//--- common/sse_pkg.sv
package sse_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned DEPTH = 8;
  localparam int unsigned PTR_W = 3;
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] LIMIT_ENH = 4'h8;
  localparam logic [3:0] LIMIT_STD = 4'h1;
  localparam logic [3:0] RX_3Q_LEVEL = 4'h6;

  localparam logic [11:0] ADDR_STAT = 12'h000;
  localparam logic [11:0] ADDR_DATA = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_ISTS = 12'h00C;
  localparam logic [11:0] ADDR_IMSK = 12'h010;

  localparam int unsigned ST_BEC_LSB = 8;
  localparam int unsigned ST_SHIFT_EMPTY = 7;
  localparam int unsigned ST_RX_OVF = 6;
  localparam int unsigned ST_RX_EMPTY = 5;
  localparam int unsigned ST_SEL_LSB = 2;
  localparam int unsigned ST_TX_FULL = 1;
  localparam int unsigned ST_RX_FULL = 0;

  localparam int unsigned CTRL_ENH = 0;
  localparam int unsigned CTRL_MST = 1;
  localparam int unsigned IRQ_SEL_EV = 0;
  localparam int unsigned IRQ_OVF_EV = 1;

  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [2:0] SEL_RST = 3'h0;

  localparam logic [2:0] SEL_TX_FULL = 3'h7;
  localparam logic [2:0] SEL_TX_EMPTY = 3'h6;
  localparam logic [2:0] SEL_TX_DONE = 3'h5;
  localparam logic [2:0] SEL_TX_ONE_FREE = 3'h4;
  localparam logic [2:0] SEL_RX_FULL = 3'h3;
  localparam logic [2:0] SEL_RX_3Q = 3'h2;
  localparam logic [2:0] SEL_RX_ANY = 3'h1;
  localparam logic [2:0] SEL_RX_LAST_READ = 3'h0;

  typedef struct packed {
    logic load;
    logic done;
    logic push;
    logic [15:0] data;
  } sse_eng_t;
endpackage

//--- design/sse_fifo.sv
`timescale 1ns/1ps
module sse_fifo
  import sse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] head,
  output logic [CNT_W-1:0] count
);
  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [DATA_W-1:0] mem_nxt [DEPTH];
  logic [PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;

  // Caller guards push against full and pop against empty
  always_comb
  begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      mem_nxt[wp_r] = wdata;
      wp_nxt = wp_r + 3'h1;
    end
    if (pop)
      rp_nxt = rp_r + 3'h1;
    if (push && !pop)
      cnt_nxt = cnt_r + 4'h1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= 16'h0000;
      wp_r <= 3'h0;
      rp_r <= 3'h0;
      cnt_r <= 4'h0;
    end
    else if (ce)
    begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign head = mem_r[rp_r];
  assign count = cnt_r;
endmodule

//--- sim/sse_spi_status_test.sv
`timescale 1ns/1ps
module sse_spi_status_test
  import sse_pkg::*;
();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sse_eng_t eng = '0;
  logic [DATA_W-1:0] tx_word;
  logic tx_word_valid;
  logic irq;
  logic err;
  logic [31:0] q;
  int miscompares = 0;
  int compares = 0;

  sse_spi_status dut (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .eng(eng),
    .tx_word(tx_word),
    .tx_word_valid(tx_word_valid),
    .irq(irq)
  );

  always #20 pclk = ~pclk;

  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("FAIL %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Pready is sampled before the edge's own updates land
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
      $display("FAIL %0t: no bus answer", $time);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  // Code bits: load, done, push
  task eng_pulse(input logic [2:0] c, input logic [15:0] d);
    eng <= {c, d};
    @(posedge pclk);
    eng <= '0;
    @(posedge pclk);
  endtask

  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #(40 * 3000);
    miscompares++;
    $display("FAIL %0t: watchdog expired", $time);
    final_report;
  end

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_STAT, 16'h00a0);
    wr(ADDR_CTRL, 16'h0003);
    wr(ADDR_IMSK, 16'h0001);
    wr(ADDR_STAT, 16'h001c);
    // Ninth word must be dropped while full
    for (int i = 0; i < 9; i++)
    begin
      if (i == 7)
        rd(ADDR_STAT, 16'h07bc);
      wr(ADDR_DATA, 32'(16'h1000 + i));
    end
    rd(ADDR_STAT, 16'h00be);
    chk(32'(irq), 1);
    wr(ADDR_STAT, 16'h0010);
    wr(ADDR_ISTS, 16'h0003);
    rd(ADDR_ISTS, 16'h0000);
    chk(32'(irq), 0);
    eng_pulse(3'b100, 16'h0000);
    chk(32'(tx_word_valid), 1);
    chk(32'(tx_word), 16'h1000);
    rd(ADDR_ISTS, 16'h0001);
    rd(ADDR_STAT, 16'h0730);
    wr(ADDR_STAT, 16'h0018);
    wr(ADDR_ISTS, 16'h0003);
    for (int i = 1; i < 8; i++)
    begin
      eng_pulse(3'b100, 16'h0000);
      chk(32'(tx_word), 32'(16'h1000 + i));
      if (i == 6)
        rd(ADDR_ISTS, 16'h0000);
    end
    rd(ADDR_ISTS, 16'h0001);
    wr(ADDR_STAT, 16'h0014);
    wr(ADDR_ISTS, 16'h0003);
    eng_pulse(3'b010, 16'h0000);
    rd(ADDR_ISTS, 16'h0001);
    rd(ADDR_STAT, 16'h00b4);
    $display("tx test done");
    wr(ADDR_ISTS, 16'h0003);
    wr(ADDR_CTRL, 16'h0001);
    for (int i = 0; i < 9; i++)
    begin
      if (i == 8)
        rd(ADDR_STAT, 16'h0095);
      eng_pulse(3'b001, 16'(16'h2000 + i));
    end
    rd(ADDR_STAT, 16'h00d5);
    rd(ADDR_ISTS, 16'h0002);
    chk(32'(irq), 0);
    wr(ADDR_IMSK, 16'h0003);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 1);
    rd(ADDR_DATA, 16'h2000);
    rd(ADDR_STAT, 16'h07d4);
    wr(ADDR_STAT, 16'h0014);
    rd(ADDR_STAT, 16'h0794);
    rd(12'h014, 16'h0000);
    chk(32'(err), 1);
    wr(ADDR_ISTS, 16'h0003);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 0);
    $display("rx test done");
    wr(ADDR_STAT, 16'h0008);
    rd(ADDR_ISTS, 16'h0001);
    rd(ADDR_DATA, 16'h2001);
    rd(ADDR_DATA, 16'h2002);
    wr(ADDR_ISTS, 16'h0003);
    rd(ADDR_ISTS, 16'h0000);
    wr(ADDR_STAT, 16'h000c);
    for (int i = 0; i < 3; i++)
    begin
      rd(ADDR_ISTS, 16'h0000);
      eng_pulse(3'b001, 16'(16'h2100 + i));
    end
    rd(ADDR_STAT, 16'h008d);
    rd(ADDR_ISTS, 16'h0001);
    // Level condition re-sets in the cycle it is cleared
    wr(ADDR_STAT, 16'h0004);
    wr(ADDR_ISTS, 16'h0003);
    rd(ADDR_ISTS, 16'h0001);
    wr(ADDR_STAT, 16'h0000);
    wr(ADDR_ISTS, 16'h0003);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7)
        rd(ADDR_ISTS, 16'h0000);
      rd(ADDR_DATA, (i < 5) ? 32'h0000_2003 + i : 32'h0000_20fb + i);
    end
    rd(ADDR_ISTS, 16'h0001);
    chk(32'(irq), 1);
    // Push while frozen must be ignored
    ce <= 1'b0;
    eng_pulse(3'b001, 16'h2200);
    ce <= 1'b1;
    rd(ADDR_STAT, 16'h00a0);
    $display("select test done");
    final_report;
  end
endmodule
